// *** src/tbt_defines.svh ***
// timing constants for the 10 Mb/s twisted-pair transceiver logic
`ifndef TBT_DEFINES_SVH
`define TBT_DEFINES_SVH
`define TBT_CLK_KHZ 40000
`define TBT_NS_FLOOR(ns) (((ns) * `TBT_CLK_KHZ) / 1000000)
`define TBT_NS_CEIL(ns) (((ns) * `TBT_CLK_KHZ + 999999) / 1000000)
`define TBT_MS_CYC(ms) ((ms) * `TBT_CLK_KHZ)
`define TBT_BIT_NS 100
`define TBT_BIT_CYC `TBT_NS_FLOOR(`TBT_BIT_NS)
`define TBT_SQ_WIN_NS 150
`define TBT_SQ_WIN_CYC `TBT_NS_FLOOR(`TBT_SQ_WIN_NS)
`define TBT_EOP_NS 150
`define TBT_EOP_CYC `TBT_NS_CEIL(`TBT_EOP_NS)
`define TBT_EOF_NS 150
`define TBT_EOF_CYC `TBT_NS_FLOOR(`TBT_EOF_NS)
`define TBT_RXCLK_TAIL_NS 500
`define TBT_RXCLK_TAIL_CYC `TBT_NS_CEIL(`TBT_RXCLK_TAIL_NS)
`define TBT_NLP_W_NS 100
`define TBT_NLP_W_CYC `TBT_NS_FLOOR(`TBT_NLP_W_NS)
`define TBT_NLP_MS 16
`define TBT_NLP_CYC `TBT_MS_CYC(`TBT_NLP_MS)
`define TBT_JAB_MS 85
`define TBT_JAB_CYC `TBT_MS_CYC(`TBT_JAB_MS)
`define TBT_UNJAB_MS 500
`define TBT_UNJAB_CYC `TBT_MS_CYC(`TBT_UNJAB_MS)
`define TBT_LINK_LOSS_MS 100
`define TBT_LINK_LOSS_CYC `TBT_MS_CYC(`TBT_LINK_LOSS_MS)
`define TBT_SQE_DLY_NS 1000
`define TBT_SQE_DLY_CYC `TBT_NS_FLOOR(`TBT_SQE_DLY_NS)
`define TBT_SQE_LEN_NS 1000
`define TBT_SQE_LEN_CYC `TBT_NS_FLOOR(`TBT_SQE_LEN_NS)
`define TBT_TX_IDL_NS 200
`define TBT_TX_IDL_CYC `TBT_NS_FLOOR(`TBT_TX_IDL_NS)
`define TBT_INV_PULSES 3
`endif

// *** src/tbt_pkg.sv ***
// types shared by the 10 Mb/s transceiver logic
package tbt_pkg;
  typedef enum logic [1:0] {TBT_SQ_IDLE, TBT_SQ_OPP, TBT_SQ_ORIG, TBT_SQ_VALID} tbt_sq_e;
  typedef struct packed {
    logic speed_10;
    logic full_duplex;
    logic sqe_test_off;
    logic link_bypass;
  } tbt_cfg_s;
  typedef struct packed {
    logic link_ok;
    logic polarity_bad;
    logic jabber;
    logic low_squelch;
  } tbt_stat_s;
  typedef struct packed {
    logic sq_pos;
    logic sq_neg;
    logic rx_line;
  } tbt_line_s;
  typedef logic [24:0] tbt_long_t;
  typedef logic [6:0] tbt_short_t;
endpackage

// *** src/tbt_xcvr.sv ***
// 10 Mb/s transceiver control: squelch, collision, carrier, link, jabber, codec
`timescale 1ns/1ps
`default_nettype none
`include "tbt_defines.svh"
// Function
// [R1] after first crossing, opposite then original crossing each within 150 ns
// [R2] qualification may swallow about three preamble bits
// [R3] data stays valid until no crossing for over 150 ns
// [R4] lower squelch thresholds once good data is seen
// [R5] squelch works the same in half and full duplex
// [R6] half duplex: overlapping transmit and receive raises collision
// [R7] jabber also raises collision
// [R8] collision holds for its duration, asserts at once during reception
// [R9] heartbeat pulse on collision about 1 us after each transmit
// [R10] no heartbeat in full duplex or with sqe_test_off set
// [R11] carrier: transmit or receive in half, receive only in full
// [R12] idle transmitter sends 100 ns link pulse every 16 ms
// [R13] without link pulses transmit, receive and collision are disabled
// [R14] link bypass forces link good
// [R15] jabber cuts transmission after about 85 ms continuous activity
// [R16] after jabber, transmit enable must stay low 500 ms to recover
// [R17] jabber only acts at 10 Mb/s
// [R18] three consecutive inverted link pulses flag bad polarity
// [R19] bad polarity is latched and receive data is inverted internally
// [R20] transmit data taken each bit clock while enable high, Manchester coded
// [R21] last transmitted transition is positive
// [R22] end of frame drops carrier in 1.5 bits; rx clock runs 5 more bits
module tbt_xcvr #(
  parameter tbt_pkg::tbt_long_t NLP_PERIOD_CYC = 25'(`TBT_NLP_CYC),
  parameter tbt_pkg::tbt_long_t JAB_CYC = 25'(`TBT_JAB_CYC),
  parameter tbt_pkg::tbt_long_t UNJAB_CYC = 25'(`TBT_UNJAB_CYC),
  parameter tbt_pkg::tbt_long_t LINK_LOSS_CYC = 25'(`TBT_LINK_LOSS_CYC)
) (
  input wire logic clock,
  input wire logic srst,
  input wire tbt_pkg::tbt_cfg_s cfg,
  input wire tbt_pkg::tbt_line_s line_in,
  input wire logic tx_en,
  input wire logic txd,
  output logic tx_clk,
  output logic crs,
  output logic col,
  output logic rx_clk,
  output logic rxd,
  output logic tx_line,
  output logic tx_drive,
  output tbt_pkg::tbt_stat_s stat
);
  import tbt_pkg::*;

  function automatic tbt_short_t sinc(input tbt_short_t v);
    return (v == 7'h7F) ? v : v + 7'h01;
  endfunction

  function automatic tbt_long_t linc(input tbt_long_t v);
    return (v == 25'h1FFFFFF) ? v : v + 25'h0000001;
  endfunction

  tbt_line_s meta_reg;
  tbt_line_s sync_reg;
  tbt_line_s prev_reg;
  logic pol_bad_reg;
  logic link_ok_reg;
  logic jabber_reg;
  logic link_use;
  logic raw_pos_rise;
  logic raw_neg_rise;
  logic p_lvl;
  logic n_lvl;
  logic p_rise;
  logic n_rise;
  logic rx_d;

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= line_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign link_use = link_ok_reg | cfg.link_bypass; // see [R14]
  assign raw_pos_rise = sync_reg.sq_pos & ~prev_reg.sq_pos;
  assign raw_neg_rise = sync_reg.sq_neg & ~prev_reg.sq_neg;
  // comparators swap roles once reversed wiring is known
  assign p_lvl = pol_bad_reg ? sync_reg.sq_neg : sync_reg.sq_pos; // see [R19]
  assign n_lvl = pol_bad_reg ? sync_reg.sq_pos : sync_reg.sq_neg; // see [R19]
  assign p_rise = pol_bad_reg ? raw_neg_rise : raw_pos_rise;
  assign n_rise = pol_bad_reg ? raw_pos_rise : raw_neg_rise;
  assign rx_d = sync_reg.rx_line ^ pol_bad_reg; // see [R19]

  // squelch qualification; duplex is deliberately not an input here
  tbt_sq_e sq_reg;
  logic first_pos_reg;
  tbt_short_t sq_tmr_reg;
  logic sq_valid;
  logic step_rise;
  logic quiet;
  assign sq_valid = (sq_reg == TBT_SQ_VALID);
  assign quiet = ~(p_lvl | n_lvl);
  assign step_rise = ((sq_reg == TBT_SQ_OPP) == first_pos_reg) ? n_rise : p_rise;

  always_ff @(posedge clock) begin // see [R5]
    if (srst) begin
      sq_reg <= TBT_SQ_IDLE;
      first_pos_reg <= 1'b0;
      sq_tmr_reg <= '0;
    end else if (!link_use) begin // see [R13]
      sq_reg <= TBT_SQ_IDLE;
      sq_tmr_reg <= '0;
    end else begin
      case (sq_reg)
        TBT_SQ_IDLE: begin
          sq_tmr_reg <= '0;
          if (p_rise | n_rise) begin
            first_pos_reg <= p_rise;
            sq_reg <= TBT_SQ_OPP;
          end
        end
        TBT_SQ_OPP, TBT_SQ_ORIG: begin
          sq_tmr_reg <= sinc(sq_tmr_reg);
          if (step_rise) begin // see [R1]
            sq_tmr_reg <= '0;
            sq_reg <= (sq_reg == TBT_SQ_OPP) ? TBT_SQ_ORIG : TBT_SQ_VALID;
          end else if (sq_tmr_reg == 7'(`TBT_SQ_WIN_CYC - 1)) begin // see [R1]
            sq_reg <= TBT_SQ_IDLE;
          end
        end
        TBT_SQ_VALID: begin
          // preamble bits spent qualifying are simply not forwarded, see [R2]
          sq_tmr_reg <= quiet ? sinc(sq_tmr_reg) : '0; // see [R3]
          if (quiet && sq_tmr_reg == 7'(`TBT_EOP_CYC)) begin // see [R3]
            sq_reg <= TBT_SQ_IDLE;
          end
        end
        default: sq_reg <= TBT_SQ_IDLE;
      endcase
    end
  end

  // manchester receive: 4-cycle gaps mark mid-bit edges, 2-cycle gaps alternate
  logic rx_prev_reg;
  logic last_mid_reg;
  logic rxd_reg;
  tbt_short_t gap_reg;
  logic rx_edge;
  logic eof;
  assign rx_edge = rx_d ^ rx_prev_reg;
  assign eof = (gap_reg >= 7'(`TBT_EOF_CYC - 1)); // see [R22]

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_prev_reg <= 1'b0;
      last_mid_reg <= 1'b0;
      rxd_reg <= 1'b0;
      gap_reg <= '0;
    end else begin
      rx_prev_reg <= rx_d;
      gap_reg <= rx_edge ? '0 : sinc(gap_reg);
      if (rx_edge) begin
        if (gap_reg >= 7'(`TBT_BIT_CYC / 2) || !last_mid_reg) begin
          rxd_reg <= rx_d;
          last_mid_reg <= 1'b1;
        end else begin
          last_mid_reg <= 1'b0;
        end
      end
    end
  end

  logic [1:0] div_reg;
  logic bit_start;
  logic bit_mid;
  assign bit_start = (div_reg == 2'h3);
  assign bit_mid = (div_reg == 2'h1);

  logic rx_crs_reg;
  logic rx_clk_reg;
  tbt_short_t tail_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      div_reg <= 2'h0;
      rx_crs_reg <= 1'b0;
      rx_clk_reg <= 1'b0;
      tail_reg <= '0;
    end else begin
      div_reg <= div_reg + 2'h1;
      rx_crs_reg <= sq_valid & ~eof; // see [R22]
      if (rx_crs_reg && !(sq_valid && !eof)) begin
        tail_reg <= 7'(`TBT_RXCLK_TAIL_CYC); // see [R22]
      end else if (tail_reg != 7'h00) begin
        tail_reg <= tail_reg - 7'h01;
      end
      // free-running phase, not recovered: good enough for frame timing only
      rx_clk_reg <= (rx_crs_reg | (tail_reg != 7'h00)) & ~div_reg[1];
    end
  end

  // transmit encoder and link pulse generator
  logic sending_reg;
  logic sending_q_reg;
  logic cur_reg;
  logic line_reg;
  logic drive_reg;
  logic tx_clk_reg;
  tbt_short_t idl_reg;
  tbt_short_t nlp_w_reg;
  tbt_long_t nlp_cnt_reg;
  logic tx_ok;
  logic nlp_fire;
  assign tx_ok = link_use & ~jabber_reg; // see [R13] [R16]
  assign nlp_fire = (nlp_cnt_reg == NLP_PERIOD_CYC);

  always_ff @(posedge clock) begin
    if (srst) begin
      sending_reg <= 1'b0;
      cur_reg <= 1'b0;
      line_reg <= 1'b0;
      drive_reg <= 1'b0;
      tx_clk_reg <= 1'b0;
      idl_reg <= '0;
      nlp_w_reg <= '0;
      nlp_cnt_reg <= '0;
    end else begin
      tx_clk_reg <= bit_start | (div_reg == 2'h0);
      nlp_cnt_reg <= (sending_reg || idl_reg != 7'h00 || nlp_fire) ? '0 : linc(nlp_cnt_reg);
      if (!tx_ok && sending_reg) begin // see [R15]
        sending_reg <= 1'b0;
        drive_reg <= 1'b0;
        line_reg <= 1'b0;
      end else if (bit_start && tx_en && tx_ok) begin // see [R20]
        sending_reg <= 1'b1;
        cur_reg <= txd;
        line_reg <= ~txd;
        drive_reg <= 1'b1;
        idl_reg <= '0;
        nlp_w_reg <= '0;
      end else if (bit_start && sending_reg) begin
        // line is driven high at cell end; after a one it already is
        sending_reg <= 1'b0;
        line_reg <= 1'b1; // see [R21]
        idl_reg <= 7'(`TBT_TX_IDL_CYC);
      end else if (bit_mid && sending_reg) begin
        line_reg <= cur_reg; // see [R20]
      end else if (idl_reg != 7'h00) begin
        idl_reg <= idl_reg - 7'h01;
        if (idl_reg == 7'h01) begin
          drive_reg <= 1'b0;
          line_reg <= 1'b0;
        end
      end else if (nlp_w_reg != 7'h00) begin
        nlp_w_reg <= nlp_w_reg - 7'h01;
        if (nlp_w_reg == 7'h01) begin
          drive_reg <= 1'b0;
          line_reg <= 1'b0;
        end
      end else if (nlp_fire && !jabber_reg && !sending_reg) begin // see [R12]
        nlp_w_reg <= 7'(`TBT_NLP_W_CYC);
        drive_reg <= 1'b1;
        line_reg <= 1'b1;
      end
    end
  end

  tbt_long_t jab_cnt_reg;
  tbt_long_t unjab_cnt_reg;

  always_ff @(posedge clock) begin
    if (srst || !cfg.speed_10) begin // see [R17]
      jabber_reg <= 1'b0;
      jab_cnt_reg <= '0;
      unjab_cnt_reg <= '0;
    end else if (!jabber_reg) begin
      unjab_cnt_reg <= '0;
      jab_cnt_reg <= sending_reg ? linc(jab_cnt_reg) : '0; // see [R15]
      if (sending_reg && jab_cnt_reg == JAB_CYC) begin
        jabber_reg <= 1'b1;
      end
    end else begin
      jab_cnt_reg <= '0;
      unjab_cnt_reg <= tx_en ? '0 : linc(unjab_cnt_reg); // see [R16]
      if (!tx_en && unjab_cnt_reg == UNJAB_CYC) begin
        jabber_reg <= 1'b0;
      end
    end
  end

  // link monitor; any isolated crossing while squelch idles counts as a pulse
  tbt_long_t link_cnt_reg;
  logic [1:0] inv_cnt_reg;
  logic nlp_rx;
  assign nlp_rx = (sq_reg == TBT_SQ_IDLE) & (raw_pos_rise | raw_neg_rise);

  always_ff @(posedge clock) begin
    if (srst) begin
      link_ok_reg <= 1'b0;
      link_cnt_reg <= '0;
      inv_cnt_reg <= 2'h0;
      pol_bad_reg <= 1'b0;
    end else begin
      link_cnt_reg <= nlp_rx ? '0 : linc(link_cnt_reg);
      if (nlp_rx) begin
        link_ok_reg <= 1'b1;
      end else if (link_cnt_reg == LINK_LOSS_CYC) begin
        link_ok_reg <= 1'b0; // see [R13]
      end
      if (nlp_rx && raw_pos_rise) begin
        inv_cnt_reg <= 2'h0;
      end else if (nlp_rx) begin
        inv_cnt_reg <= (inv_cnt_reg == 2'h3) ? inv_cnt_reg : inv_cnt_reg + 2'h1;
        if (inv_cnt_reg == 2'(`TBT_INV_PULSES - 1)) begin
          pol_bad_reg <= 1'b1; // see [R18] [R19]
        end
      end
    end
  end

  tbt_short_t sqe_reg;
  logic sqe_on;
  logic col_reg;
  logic crs_reg;
  assign sqe_on = (sqe_reg > 7'(`TBT_SQE_DLY_CYC));

  always_ff @(posedge clock) begin
    if (srst) begin
      sending_q_reg <= 1'b0;
      sqe_reg <= '0;
      col_reg <= 1'b0;
      crs_reg <= 1'b0;
    end else begin
      sending_q_reg <= sending_reg;
      if (cfg.full_duplex || cfg.sqe_test_off) begin
        sqe_reg <= '0; // see [R10]
      end else if (sending_q_reg && !sending_reg && !jabber_reg) begin
        sqe_reg <= 7'h01; // see [R9]
      end else if (sqe_reg == 7'(`TBT_SQE_DLY_CYC + `TBT_SQE_LEN_CYC)) begin
        sqe_reg <= '0;
      end else if (sqe_reg != 7'h00) begin
        sqe_reg <= sqe_reg + 7'h01;
      end
      // level follows the overlap, so it lasts exactly as long, see [R8]
      col_reg <= jabber_reg | (~cfg.full_duplex & link_use & // see [R6] [R7] [R9]
                 ((sending_reg & sq_valid) | sqe_on));
      crs_reg <= rx_crs_reg | (~cfg.full_duplex & sending_reg); // see [R11]
    end
  end

  assign tx_clk = tx_clk_reg;
  assign crs = crs_reg;
  assign col = col_reg;
  assign rx_clk = rx_clk_reg;
  assign rxd = rxd_reg;
  assign tx_line = line_reg;
  assign tx_drive = drive_reg;
  assign stat = tbt_stat_s'({link_ok_reg, pol_bad_reg, jabber_reg, sq_valid}); // see [R4]

  default clocking dcb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_opp_entry;
    $rose(sq_reg == TBT_SQ_OPP);
  endsequence
  sequence s_tx_end;
    sending_q_reg && !sending_reg && !jabber_reg;
  endsequence

  AST_SQ_WINDOW: assert property (s_opp_entry |-> ##[1:6] (sq_reg != TBT_SQ_OPP)) // see [R1]
    else $error("squelch waited too long for opposite crossing");
  AST_EOP: assert property (sq_valid ##0 quiet [*8] |=> !rx_crs_reg) // see [R3]
    else $error("no end of packet after quiet line");
  AST_COL_OVERLAP: assert property (!cfg.full_duplex && link_use && sending_reg && sq_valid
    |=> col_reg) // see [R6]
    else $error("overlap did not raise collision");
  AST_COL_JAB: assert property (jabber_reg |=> col_reg) // see [R7]
    else $error("jabber did not raise collision");
  AST_SQE_LEN: assert property ($rose(sqe_on) |-> sqe_on [*8]) // see [R9]
    else $error("heartbeat pulse too short");
  AST_SQE_START: assert property (s_tx_end |=> !sqe_on [*8]) // see [R9]
    else $error("heartbeat came too early");
  AST_SQE_OFF: assert property (cfg.full_duplex || cfg.sqe_test_off |=> !sqe_on) // see [R10]
    else $error("heartbeat not suppressed");
  AST_CRS_FD: assert property (cfg.full_duplex |=> (crs_reg == $past(rx_crs_reg))) // see [R11]
    else $error("full duplex carrier follows transmit");
  AST_JAB_CUT: assert property (jabber_reg |=> !drive_reg) // see [R15]
    else $error("transmitter driving during jabber");
  AST_POL: assert property ($rose(pol_bad_reg) |-> $past(inv_cnt_reg) == 2'h2) // see [R18]
    else $error("polarity flagged without three inverted pulses");
  AST_FINAL_POS: assert property ($fell(drive_reg) && $past(tx_ok) |-> $past(line_reg)) // see [R21]
    else $error("frame did not end high");
  AST_RXCLK_TAIL: assert property ($fell(rx_crs_reg) |=> (tail_reg != 7'h00) [*8]) // see [R22]
    else $error("receive clock stopped early");
endmodule
`default_nettype wire

// *** tb/tbt_line_model.sv ***
// line-side model of the remote transceiver
`timescale 1ns/1ps
`default_nettype none
module tbt_line_model (
  input wire logic clock,
  output var tbt_pkg::tbt_line_s line_out
);
  import tbt_pkg::*;
  initial line_out = '0;
  // single crossing held 4 cycles; neg mimics a swapped pair
  task automatic pulse(input logic neg);
    @(posedge clock) #2 line_out = {~neg, neg, ~neg};
    repeat (4) @(posedge clock);
    // released line shows the inverse level, not the last one
    #2 line_out = {2'b00, ~line_out.rx_line};
  endtask
  // alternating crossings, one per half bit of 2 cycles
  task automatic frame(input int halves);
    for (int i = 0; i < halves; i++) begin
      @(posedge clock) #2 line_out = {~i[0], i[0], ~i[0]};
      @(posedge clock);
    end
    #2 line_out = {2'b00, ~line_out.rx_line};
  endtask
endmodule
`default_nettype wire

// *** tb/tenbase_t_transceiver_logic_tb_top.sv ***
// self-checking bench for the 10 Mb/s transceiver logic
`timescale 1ns/1ps
`default_nettype none
`include "tbt_defines.svh"
module tenbase_t_transceiver_logic_tb_top;
  import tbt_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  tbt_cfg_s cfg = 4'h8;
  tbt_line_s line_in;
  logic tx_en = 1'b0;
  logic txd = 1'b0;
  logic tx_clk, crs, col, rx_clk, rxd, tx_line, tx_drive;
  tbt_stat_s stat;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int col_n = 0;
  int crs_n = 0;
  int rxc_n = 0;
  always #12.5 clock = ~clock;
  // short counts keep the run small
  tbt_xcvr #(.NLP_PERIOD_CYC(25'h00000C8), .JAB_CYC(25'h000012C),
    .UNJAB_CYC(25'h0000190), .LINK_LOSS_CYC(25'h00003E8)) u_tbt_xcvr (
    .clock(clock), .srst(srst), .cfg(cfg), .line_in(line_in),
    .tx_en(tx_en), .txd(txd), .tx_clk(tx_clk), .crs(crs), .col(col),
    .rx_clk(rx_clk), .rxd(rxd), .tx_line(tx_line),
    .tx_drive(tx_drive), .stat(stat));
  tbt_line_model u_tbt_line_model (.clock(clock), .line_out(line_in));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    col_n += int'(col === 1'b1);
    crs_n += int'(crs === 1'b1);
    rxc_n += int'(rx_clk === 1'b1);
    if (cyc == 20000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // settle past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  // mac side: new bit right after each bit clock rise, tx_en drops after
  task automatic tx_bits(input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge tx_clk) #2;
      tx_en = (i < n);
      txd = (i < n) ? i[0] : 1'b0;
    end
  endtask
  task automatic t_nlp();
    int w, p;
    w = 0;
    p = 0;
    while (tx_drive !== 1'b1 && p < 300) begin tick(1); p++; end
    while (tx_drive === 1'b1 && w < 20) begin tick(1); w++; end
    chk(w == `TBT_NLP_W_CYC, "link pulse width");
    p = w;
    while (tx_drive !== 1'b1 && p < 300) begin tick(1); p++; end
    chk(p >= 200 && p <= 204, "link pulse period");
  endtask
  task automatic t_link();
    chk(stat.link_ok === 1'b0, "link before pulses");
    crs_n = 0;
    tx_bits(8);
    chk(crs_n == 0, "send without link");
    u_tbt_line_model.pulse(1'b0);
    tick(10);
    chk(stat.link_ok === 1'b1 && crs_n == 0, "lone pulse");
    tick(1100);
    chk(stat.link_ok === 1'b0, "link loss");
  endtask
  task automatic t_rx(input logic fd);
    int k;
    cfg.full_duplex = fd;
    k = 0;
    fork
      u_tbt_line_model.frame(64);
      begin
        while (crs !== 1'b1 && k < 40) begin tick(1); k++; end
        chk(k <= 20 && stat.low_squelch === 1'b1, "qualify");
        crs_n = 0;
      end
    join
    k = 0;
    chk(crs_n >= 100, "carrier held");
    while (crs === 1'b1 && k < 40) begin tick(1); k++; end
    chk(k <= 14, "carrier drop");
    rxc_n = 0;
    tick(20);
    chk(rxc_n >= 8 && rxc_n <= 12, "rx clock tail");
  endtask
  task automatic t_tx(input logic fd, input logic off, input int sqe);
    logic last;
    int k;
    cfg.full_duplex = fd;
    cfg.sqe_test_off = off;
    crs_n = 0;
    k = 0;
    last = 1'b0;
    tx_bits(15);
    chk((crs_n > 0) == !fd, "carrier on send");
    while (tx_drive === 1'b1 && k < 20) begin last = tx_line; tick(1); k++; end
    chk(last === 1'b1, "line ends high");
    col_n = 0;
    tick(150);
    chk(col_n == sqe, "heartbeat length");
  endtask
  task automatic t_col(input logic fd);
    cfg.full_duplex = fd;
    cfg.sqe_test_off = 1'b0;
    fork
      u_tbt_line_model.frame(96);
      begin
        tick(30);
        col_n = 0;
        tx_bits(16);
      end
    join
    chk(fd ? col_n == 0 : col_n >= 60, "overlap collision");
    tick(150);
  endtask
  task automatic t_jab();
    int k;
    cfg.full_duplex = 1'b0;
    k = 0;
    @(posedge tx_clk) #2 tx_en = 1'b1;
    txd = 1'b1;
    while (stat.jabber !== 1'b1 && k < 400) begin tick(1); k++; end
    chk(k >= 290 && k <= 320, "jabber time");
    tick(2);
    chk(col === 1'b1 && tx_drive === 1'b0, "jabber cut");
    tick(500);
    chk(stat.jabber === 1'b1 && tx_drive === 1'b0, "held off");
    tx_en = 1'b0;
    tick(350);
    chk(stat.jabber === 1'b1, "unjab early");
    k = 0;
    while (stat.jabber === 1'b1 && k < 100) begin tick(1); k++; end
    chk(k <= 80, "unjab");
    cfg.speed_10 = 1'b0;
    tx_en = 1'b1;
    tick(400);
    chk(stat.jabber === 1'b0, "no jabber off speed");
    tx_en = 1'b0;
    cfg.speed_10 = 1'b1;
    tick(10);
  endtask
  task automatic t_pol();
    repeat (2) begin
      u_tbt_line_model.pulse(1'b1);
      tick(30);
    end
    chk(stat.polarity_bad === 1'b0, "two inverted");
    u_tbt_line_model.pulse(1'b1);
    tick(10);
    chk(stat.polarity_bad === 1'b1, "three inverted");
    tick(100);
    chk(stat.polarity_bad === 1'b1, "polarity latched");
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #2 srst = 1'b0;
    tick(1);
    chk({crs, col, rx_clk, rxd, tx_line, tx_drive, stat} === 10'h000, "reset");
    // divider restarts at zero, so the bit clock is high right after release
    chk(tx_clk === 1'b1, "bit clock after reset");
    t_nlp();
    t_link();
    // forced link keeps the long scenarios clear of link loss
    cfg.link_bypass = 1'b1;
    t_rx(1'b0);
    t_rx(1'b1);
    t_tx(1'b0, 1'b0, `TBT_SQE_LEN_CYC);
    t_tx(1'b0, 1'b1, 0);
    t_tx(1'b1, 1'b0, 0);
    t_col(1'b0);
    t_col(1'b1);
    t_jab();
    t_pol();
    tally_and_finish();
  end
endmodule
`default_nettype wire
